// file: srs_pkg.sv
// Package: constants and carrier types for the supply reset supervisor
package srs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 50000000;
	localparam int unsigned HOLD_MIN_MS = 140;
	localparam int unsigned HOLD_MAX_MS = 560;
	// Least time rounds up to whole cycles
	localparam longint unsigned HOLD_MIN_CYC = (longint'(HOLD_MIN_MS) * CLK_FREQ_HZ + 999) / 1000;
	// Longest time rounds down
	localparam longint unsigned HOLD_MAX_CYC = (longint'(HOLD_MAX_MS) * CLK_FREQ_HZ) / 1000;
	localparam int unsigned CNT_W = 25;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_N_ASSERTED = 1'h0;
	localparam logic SYNC_RESET_VAL = 1'h1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRS_HOLD = 2'h1,
		SRS_RUN = 2'h2
	} srs_state_e;

	typedef struct packed {
		logic supply_low;
		logic manual_reset_n;
	} srs_cause_s;

	typedef struct packed {
		logic reset_n;
		logic reset;
	} srs_reset_s;

endpackage : srs_pkg

// file: srs_sync.sv
// Two-flop synchroniser for the asynchronous cause inputs
`timescale 1ns/1ps

module srs_sync (
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Data
	input wire srs_pkg::srs_cause_s raw_in,
	output srs_pkg::srs_cause_s sync_out
);

	srs_pkg::srs_cause_s meta_q;
	srs_pkg::srs_cause_s sync_q;

	// Both stages reset to the inactive cause levels
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			meta_q <= '{supply_low: ~srs_pkg::SYNC_RESET_VAL, manual_reset_n: srs_pkg::SYNC_RESET_VAL};
			sync_q <= '{supply_low: ~srs_pkg::SYNC_RESET_VAL, manual_reset_n: srs_pkg::SYNC_RESET_VAL};
		end else if (clk_en_in) begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : srs_sync

// file: srs_supervisor.sv
// Supply reset supervisor: holds reset while a cause is present, then for a timeout
//
// Operation
// - Reset low while supply below trip level.
// - Reset guaranteed low throughout low-supply band.
// - Timer starts on recovery; release after timeout.
// - Supply dip clears timer, asserts reset immediately.
// - Low manual reset input asserts reset.
// - Hold full timeout after manual reset released.
// - Undriven manual reset reads high, inactive.
// - Active-high output is exact inverse.
// - Timeout between 140 and 560 ms.
`timescale 1ns/1ps

module srs_supervisor #(
	parameter longint unsigned HOLD_CYCLES = srs_pkg::HOLD_MIN_CYC
) (
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Reset causes, asynchronous
	input wire logic supply_low_in,
	input wire logic manual_reset_n_in,
	// Reset outputs
	output logic reset_n_out,
	output logic reset_out
);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	srs_pkg::srs_cause_s cause_raw;
	srs_pkg::srs_cause_s cause_sync;

	assign cause_raw.supply_low = supply_low_in;
	assign cause_raw.manual_reset_n = manual_reset_n_in;

	// Causes are levels, so one shared synchroniser loses nothing
	srs_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.raw_in(cause_raw),
		.sync_out(cause_sync)
	);

	// ----------------------------------------
	// Cause combination
	// ----------------------------------------
	// Pull-up on the pin means an open input arrives as 1, so it never asserts
	logic cause_active;
	assign cause_active = cause_sync.supply_low | ~cause_sync.manual_reset_n;

	// ----------------------------------------
	// Timeout state machine
	// ----------------------------------------
	// Timer parks on its last value, so a long run never wraps
	localparam logic [srs_pkg::CNT_W-1:0] HOLD_LAST = srs_pkg::CNT_W'(HOLD_CYCLES - 1);

	srs_pkg::srs_state_e state_q;
	srs_pkg::srs_state_e state_d;
	logic [srs_pkg::CNT_W-1:0] count_q;
	logic released_q;
	logic timeout_done;

	assign timeout_done = (state_q == srs_pkg::SRS_RUN) && (count_q == HOLD_LAST) && !cause_active;

	// HOLD while any cause stands, RUN while the timer counts
	always_comb begin
		state_d = state_q;
		case (state_q)
			srs_pkg::SRS_HOLD: begin
				if (!cause_active) begin
					state_d = srs_pkg::SRS_RUN;
				end
			end
			srs_pkg::SRS_RUN: begin
				if (cause_active) begin
					state_d = srs_pkg::SRS_HOLD;
				end
			end
			default: begin
				state_d = srs_pkg::SRS_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_q <= srs_pkg::SRS_HOLD;
		end else if (clk_en_in) begin
			state_q <= state_d;
		end
	end

	// Timer clears to zero whenever a cause is present
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			count_q <= '0;
		end else if (clk_en_in) begin
			if (cause_active || state_q != srs_pkg::SRS_RUN) begin
				count_q <= '0;
			end else if (count_q != HOLD_LAST) begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	// Release is registered; any cause drops it on the next edge
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			released_q <= 1'b0;
		end else if (clk_en_in) begin
			if (cause_active) begin
				released_q <= 1'b0;
			end else if (timeout_done) begin
				released_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Both variants come from one register, so they never disagree
	srs_pkg::srs_reset_s rst_vec;
	assign rst_vec.reset_n = released_q ? 1'b1 : srs_pkg::RST_N_ASSERTED;
	assign rst_vec.reset = ~rst_vec.reset_n;
	assign reset_n_out = rst_vec.reset_n;
	assign reset_out = rst_vec.reset;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Shadow count of low cycles since the causes last cleared; timing
	// checks lean on it rather than on the timer that they guard
	localparam logic [srs_pkg::CNT_W-1:0] HOLD_FULL = srs_pkg::CNT_W'(HOLD_CYCLES);
	localparam logic [srs_pkg::CNT_W-1:0] HOLD_CEIL = srs_pkg::CNT_W'(srs_pkg::HOLD_MAX_CYC);
	logic [srs_pkg::CNT_W-1:0] low_run_q;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			low_run_q <= '0;
		end else if (clk_en_in) begin
			if (reset_n_out) begin
				low_run_q <= '0;
			end else if (!cause_active && low_run_q != '1) begin
				low_run_q <= low_run_q + 1'b1;
			end else if (cause_active) begin
				low_run_q <= '0;
			end
		end
	end

	chk_supply_holds_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		cause_sync.supply_low && clk_en_in |=> !reset_n_out)
		else $error("reset released while supply low");
	chk_band_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$past(cause_sync.supply_low) && $past(clk_en_in) |-> reset_n_out == 1'b0)
		else $error("reset not low in low-supply band");
	// Release follows exactly the full hold after the last cause
	chk_release_timing: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(reset_n_out) |-> $past(low_run_q) == HOLD_FULL)
		else $error("reset released before full timeout");
	chk_release_after_run: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(reset_n_out) |-> $past(state_q) == srs_pkg::SRS_RUN && !$past(cause_active))
		else $error("reset released without a finished run");
	chk_run_entry: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_q == srs_pkg::SRS_HOLD && !cause_active && clk_en_in |=> state_q == srs_pkg::SRS_RUN && count_q == '0)
		else $error("timer did not start from zero");
	chk_count_steps: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_q == srs_pkg::SRS_RUN && !cause_active && clk_en_in && count_q != HOLD_LAST |=> count_q == $past(count_q) + 1'b1)
		else $error("timer did not advance");
	chk_count_limit: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		count_q <= HOLD_LAST)
		else $error("timer ran past its last value");
	chk_dip_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		cause_sync.supply_low && clk_en_in |=> count_q == '0)
		else $error("timer not cleared by supply dip");
	chk_manual_asserts: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!cause_sync.manual_reset_n && clk_en_in |=> !reset_n_out && count_q == '0)
		else $error("manual reset did not assert");
	chk_manual_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(cause_sync.manual_reset_n) && !cause_sync.supply_low |-> !reset_n_out [*2])
		else $error("reset released right after manual reset");
	chk_open_input: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		reset_n_out && cause_sync.manual_reset_n && !cause_sync.supply_low && clk_en_in |=> reset_n_out)
		else $error("inactive inputs dropped reset");
	chk_inverse_out: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		reset_out == !reset_n_out)
		else $error("outputs not inverse");
	chk_hold_bound: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!reset_n_out |-> low_run_q <= HOLD_FULL)
		else $error("reset held longer than the timeout");
	chk_hold_ceiling: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		low_run_q <= HOLD_CEIL)
		else $error("timeout above the longest bound");
	// A renewed cause drops straight back to HOLD with a cleared timer
	chk_restart_timer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_q == srs_pkg::SRS_RUN && cause_active && clk_en_in |=> state_q == srs_pkg::SRS_HOLD && count_q == '0 && !reset_n_out)
		else $error("timer not restarted");
	chk_state_legal: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_q == srs_pkg::SRS_HOLD || state_q == srs_pkg::SRS_RUN)
		else $error("state machine in an unknown state");
	// Enable low must freeze every stage, synchroniser too
	chk_freeze_state: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!clk_en_in |=> $stable(count_q) && $stable(state_q) && $stable(released_q) && $stable(cause_sync))
		else $error("state moved while clock enable low");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	// Main scenarios that the bench should reach
	cov_release: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(reset_n_out));
	cov_brownout: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_q == srs_pkg::SRS_RUN && cause_sync.supply_low);
	cov_manual: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		reset_n_out ##1 !cause_sync.manual_reset_n);
	cov_freeze: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!clk_en_in && !reset_n_out && state_q == srs_pkg::SRS_RUN);
	cov_restart: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		state_q == srs_pkg::SRS_RUN && !reset_n_out && !cause_sync.manual_reset_n);

endmodule : srs_supervisor

// file: srs_cpu_model.sv
// Partner model: processor reset input and a manual reset switch with pull-up
`timescale 1ns/1ps

module srs_cpu_model (
	// Reset lines from the supervisor
	input wire logic reset_n_in,
	input wire logic reset_in,
	// Switch to ground, open otherwise
	input wire logic press_in,
	// Manual reset wire and processor state
	output logic manual_reset_n_out,
	output logic in_reset_out
);
	// Pull-up wins when the switch is open
	assign manual_reset_n_out = press_in ? 1'h0 : 1'h1;
	assign in_reset_out = ~reset_n_in & reset_in;
endmodule : srs_cpu_model

// file: testbench.sv
// Self-checking testbench for the supply reset supervisor
`timescale 1ns/1ps

module testbench;
	// Short hold keeps the run brief
	localparam int HOLD = 16;
	// Edges from a pin change to release, on top of HOLD: two syncs, one register
	localparam int PIN_LAT = 3;
	logic clk_sys_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic supply_low = 1'h0;
	logic press = 1'h0;
	logic clk_en = 1'h1;
	logic manual_reset_n;
	logic reset_n;
	logic reset;
	logic in_reset;
	int error_cnt = 0;
	int total_checks = 0;

	srs_supervisor #(.HOLD_CYCLES(HOLD)) srs_supervisor_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en), .supply_low_in(supply_low), .manual_reset_n_in(manual_reset_n),
		.reset_n_out(reset_n), .reset_out(reset));
	srs_cpu_model srs_cpu_model_inst (.reset_n_in(reset_n), .reset_in(reset), .press_in(press),
		.manual_reset_n_out(manual_reset_n), .in_reset_out(in_reset));

	initial begin
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	task automatic check(input logic seen, input logic exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic set_causes(input logic sl, input logic pr);
		@(posedge clk_sys_in);
		supply_low <= sl;
		press <= pr;
	endtask : set_causes

	task automatic hold_low(input int n, input string msg);
		repeat (n) @(posedge clk_sys_in);
		#1;
		check(reset_n, 1'h0, msg);
		check(in_reset, 1'h1, msg);
	endtask : hold_low

	// Counts edges from the last cause clearing until release
	task automatic wait_release(input int exp_n, input string msg);
		int n;
		n = 0;
		while (reset_n !== 1'h1 && n < 100) begin
			@(posedge clk_sys_in);
			#1;
			check(reset ^ reset_n, 1'h1, "outputs not inverse");
			n++;
		end
		check(n == exp_n, 1'h1, msg);
	endtask : wait_release

	task automatic t_supply;
		set_causes(1'h1, 1'h0);
		hold_low(30, "low supply not held");
		set_causes(1'h0, 1'h0);
		wait_release(HOLD + PIN_LAT, "supply hold wrong");
		$display("test supply done");
	endtask : t_supply

	task automatic t_brownout;
		set_causes(1'h1, 1'h0);
		hold_low(5, "brownout not asserted");
		set_causes(1'h0, 1'h0);
		hold_low(8, "released too early");
		// Short dip mid-timeout must restart the count
		set_causes(1'h1, 1'h0);
		hold_low(2, "dip lost");
		set_causes(1'h0, 1'h0);
		wait_release(HOLD + PIN_LAT, "timer not cleared by dip");
		$display("test brownout done");
	endtask : t_brownout

	task automatic t_manual;
		set_causes(1'h0, 1'h1);
		hold_low(5, "manual reset ignored");
		set_causes(1'h0, 1'h0);
		hold_low(10, "manual hold short");
		set_causes(1'h0, 1'h1);
		hold_low(3, "second press lost");
		set_causes(1'h0, 1'h0);
		wait_release(HOLD + PIN_LAT, "manual hold wrong");
		$display("test manual done");
	endtask : t_manual

	task automatic t_open;
		set_causes(1'h0, 1'h0);
		repeat (50) @(posedge clk_sys_in);
		#1;
		check(reset_n, 1'h1, "open input caused reset");
		check(reset, 1'h0, "high output wrong");
		$display("test open done");
	endtask : t_open

	task automatic t_freeze;
		set_causes(1'h1, 1'h0);
		hold_low(5, "freeze setup lost");
		set_causes(1'h0, 1'h0);
		repeat (6) @(posedge clk_sys_in);
		clk_en <= 1'h0;
		hold_low(20, "released while frozen");
		@(posedge clk_sys_in);
		clk_en <= 1'h1;
		// Six enabled edges ran before the freeze
		wait_release(HOLD + PIN_LAT - 6, "frozen timer moved");
		$display("test freeze done");
	endtask : t_freeze

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	initial begin
		repeat (4) @(posedge clk_sys_in);
		#1;
		check(reset_n, 1'h0, "reset not low at power-on");
		check(reset, 1'h1, "high output wrong at power-on");
		@(posedge clk_sys_in);
		rst_n_in <= 1'h1;
		wait_release(HOLD + 1, "power-on hold wrong");
		$display("test power_on done");
		t_supply();
		t_brownout();
		t_manual();
		t_open();
		t_freeze();
		results();
	end

	// Tests need well under 1000 cycles
	initial begin
		#60000;
		error_cnt++;
		results();
	end
endmodule : testbench
